// ===== logic/lpo_pkg.sv
// Package for the LCD pin override and port A/B register block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
//
// Overview of operation
// [R1] LCD on, mask above 5: G4 to plane 23
// [R2] LCD on, mask above 6: G3 to plane 24
// [R3] LCD on: G2 taken for plane 4
// [R4] LCD on, mask above 0: G1, G0 taken
// [R5] G4 input feeds timer 0; no value override
// [R6] G3 input feeds timer 1 too
// [R7] G1 to segment 13, G0 to plane 14
// [R8] Port A output value, eight bits, reset 0
// [R9] Port A direction, eight bits, reset 0
// [R10] Port A sample follows the pads
// [R11] Port B output value, eight bits, reset 0
// [R12] Port B direction, eight bits, reset 0
// [R13] Direction one drives pin from output value
`default_nettype none
package lpo_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] ADDR_PA_OUT = 8'h00;
    localparam logic [7:0] ADDR_PA_DIR = 8'h04;
    localparam logic [7:0] ADDR_PA_PIN = 8'h08;
    localparam logic [7:0] ADDR_PB_OUT = 8'h0c;
    localparam logic [7:0] ADDR_PB_DIR = 8'h10;
    localparam logic [7:0] ADDR_PB_PIN = 8'h14;
    localparam logic [7:0] ADDR_LCD_CTL = 8'h18;
    localparam logic [7:0] ADDR_PG_STAT = 8'h1c;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int LCD_ON_POS = 0;    // lcd_on_bit in the LCD control word
    localparam int LCD_MASK_LSB = 4;  // lcd_segment_port_mask low bit
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [3:0] MASK_G4 = 4'h5;  // Mask must exceed this for G4
    localparam logic [3:0] MASK_G3 = 4'h6;  // Mask must exceed this for G3
    localparam logic [3:0] MASK_G10 = 4'h0; // Mask must exceed this for G1/0
    localparam int PG_WIDTH = 5;
    localparam int PORT_WIDTH = 8;

    // Per-pin override bundle handed to each port G pad
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic port_value_override_enable;
        logic port_value_override_value;
        logic input_enable_override_enable;
        logic input_enable_override_value;
        logic analog_pad_link;
    } lpo_ovr_t;

    // Wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } lpo_wb_req_t;

endpackage
`default_nettype wire

// ===== logic/lpo_top.sv
// Port A/B registers and port G LCD pin override logic.
// Assumes pad inputs are synchronous to clk_i and a classic Wishbone
// master that holds its request until ack.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`default_nettype none
`timescale 1ns/10ps
module lpo_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire lpo_pkg::lpo_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] pa_pad_i,
    output logic [7:0] pa_out_o,
    output logic [7:0] pa_oe_o,
    input wire logic [7:0] pb_pad_i,
    output logic [7:0] pb_out_o,
    output logic [7:0] pb_oe_o,
    input wire logic [4:0] pg_pad_i,
    output lpo_pkg::lpo_ovr_t [4:0] pg_ovr_o,
    output logic timer0_count_source_o,
    output logic timer1_count_source_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0] pa_out, next_pa_out;     // Port A output value
    logic [7:0] pa_dir, next_pa_dir;     // Port A direction
    logic [7:0] pa_pin, next_pa_pin;     // Port A pin sample
    logic [7:0] pb_out, next_pb_out;     // Port B output value
    logic [7:0] pb_dir, next_pb_dir;     // Port B direction
    logic [7:0] pb_pin, next_pb_pin;     // Port B pin sample
    logic lcd_on_bit, next_lcd_on_bit;   // LCD enable from software
    logic [3:0] lcd_segment_port_mask, next_lcd_segment_port_mask;
    logic ack, next_ack;                 // Wishbone acknowledge
    logic [31:0] rdat, next_rdat;        // Registered read data
    logic [4:0] take;                    // Port G pins owned by the LCD
    lpo_pkg::lpo_ovr_t [4:0] ovr, next_ovr;
    logic t0, next_t0;
    logic t1, next_t1;

    // Access strobe; a new one only after the previous ack dropped
    logic acc;
    assign acc = wb_req_i.cyc & wb_req_i.stb & ~ack;

    ////////////////////////////////////////////////////////////////////////
    // Ownership decode for port G, one term per pin
    always_comb begin
        take[4] = lcd_on_bit && (lcd_segment_port_mask > lpo_pkg::MASK_G4); // [R1]
        take[3] = lcd_on_bit && (lcd_segment_port_mask > lpo_pkg::MASK_G3); // [R2]
        take[2] = lcd_on_bit; // [R3]
        take[1] = lcd_on_bit && (lcd_segment_port_mask > lpo_pkg::MASK_G10); // [R4]
        take[0] = take[1]; // [R4]
    end

    ////////////////////////////////////////////////////////////////////////
    // Override bundle, built per pin by one loop
    // Only G4 forces its direction value high; the others force zero
    genvar g;
    generate
        for (g = 0; g < lpo_pkg::PG_WIDTH; g = g + 1) begin : g_ovr
            always_comb begin
                next_ovr[g].pullup_override_enable = take[g]; // [R1] [R2] [R3]
                next_ovr[g].pullup_override_value = 1'b0;
                next_ovr[g].direction_override_enable = take[g]; // [R4]
                next_ovr[g].direction_override_value = (g == 4); // [R1] [R2]
                next_ovr[g].port_value_override_enable = 1'b0; // [R5]
                next_ovr[g].port_value_override_value = 1'b0; // [R5]
                next_ovr[g].input_enable_override_enable = take[g]; // [R3]
                next_ovr[g].input_enable_override_value = 1'b0; // [R4]
                // Analog link closes only while the LCD owns the pin
                next_ovr[g].analog_pad_link = take[g]; // [R7]
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Timer count sources; digital input is gated off once the LCD owns it
    always_comb begin
        next_t0 = pg_pad_i[4] & ~take[4]; // [R5]
        next_t1 = pg_pad_i[3] & ~take[3]; // [R6]
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file next state and Wishbone decode
    always_comb begin
        next_pa_out = pa_out;
        next_pa_dir = pa_dir;
        next_pb_out = pb_out;
        next_pb_dir = pb_dir;
        next_lcd_on_bit = lcd_on_bit;
        next_lcd_segment_port_mask = lcd_segment_port_mask;
        // Samples follow the pads every cycle that ce_i is high; reset loads PORT_RESET
        next_pa_pin = pa_pad_i; // [R10]
        next_pb_pin = pb_pad_i;
        next_ack = acc;
        next_rdat = 32'h0000_0000;
        if (acc && wb_req_i.we && wb_req_i.sel[0]) begin
            // Writes to sample registers are ignored
            if (wb_req_i.adr == lpo_pkg::ADDR_PA_OUT) begin
                next_pa_out = wb_req_i.dat[7:0]; // [R8]
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PA_DIR) begin
                next_pa_dir = wb_req_i.dat[7:0]; // [R9]
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PB_OUT) begin
                next_pb_out = wb_req_i.dat[7:0]; // [R11]
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PB_DIR) begin
                next_pb_dir = wb_req_i.dat[7:0]; // [R12]
            end else if (wb_req_i.adr == lpo_pkg::ADDR_LCD_CTL) begin
                next_lcd_on_bit = wb_req_i.dat[lpo_pkg::LCD_ON_POS];
                next_lcd_segment_port_mask =
                    wb_req_i.dat[lpo_pkg::LCD_MASK_LSB +: 4];
            end
        end
        if (acc && !wb_req_i.we) begin
            // Unmapped addresses read as zero and still acknowledge
            if (wb_req_i.adr == lpo_pkg::ADDR_PA_OUT) begin
                next_rdat[7:0] = pa_out;
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PA_DIR) begin
                next_rdat[7:0] = pa_dir;
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PA_PIN) begin
                next_rdat[7:0] = pa_pin; // [R10]
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PB_OUT) begin
                next_rdat[7:0] = pb_out;
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PB_DIR) begin
                next_rdat[7:0] = pb_dir;
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PB_PIN) begin
                next_rdat[7:0] = pb_pin;
            end else if (wb_req_i.adr == lpo_pkg::ADDR_LCD_CTL) begin
                next_rdat[lpo_pkg::LCD_ON_POS] = lcd_on_bit;
                next_rdat[lpo_pkg::LCD_MASK_LSB +: 4] = lcd_segment_port_mask;
            end else if (wb_req_i.adr == lpo_pkg::ADDR_PG_STAT) begin
                next_rdat[4:0] = take;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; clock enable freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_out <= lpo_pkg::PORT_RESET; // [R8]
            pa_dir <= lpo_pkg::PORT_RESET; // [R9]
            pb_out <= lpo_pkg::PORT_RESET; // [R11]
            pb_dir <= lpo_pkg::PORT_RESET; // [R12]
            pa_pin <= lpo_pkg::PORT_RESET;
            pb_pin <= lpo_pkg::PORT_RESET;
            lcd_on_bit <= 1'b0;
            lcd_segment_port_mask <= lpo_pkg::MASK_RESET;
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
            ovr <= '0;
            t0 <= 1'b0;
            t1 <= 1'b0;
        end else if (ce_i) begin
            pa_out <= next_pa_out;
            pa_dir <= next_pa_dir;
            pb_out <= next_pb_out;
            pb_dir <= next_pb_dir;
            pa_pin <= next_pa_pin;
            pb_pin <= next_pb_pin;
            lcd_on_bit <= next_lcd_on_bit;
            lcd_segment_port_mask <= next_lcd_segment_port_mask;
            ack <= next_ack;
            rdat <= next_rdat;
            ovr <= next_ovr;
            t0 <= next_t0;
            t1 <= next_t1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops; pad drive changes on the same edge as the write, with ack,
    // since the output registers themselves are the pad drivers
    assign pa_out_o = pa_out; // [R13]
    assign pa_oe_o = pa_dir;  // [R13]
    assign pb_out_o = pb_out; // [R13]
    assign pb_oe_o = pb_dir;  // [R13]
    assign pg_ovr_o = ovr;
    assign timer0_count_source_o = t0; // [R5]
    assign timer1_count_source_o = t1; // [R6]
    assign wb_dat_o = rdat;
    assign wb_ack_o = ack;

endmodule
`default_nettype wire

// ===== tb/lpo_pads.sv
// Pad model for one eight-pin port.
// Assumes no pull resistors; an input pin shows the outside level.
`timescale 1ns/10ps
`default_nettype none
module lpo_pads (
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] ext_i,
    output logic [7:0] pad_o
);
    // A driving pin wins over the outside level
    assign pad_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ===== tb/lpo_sva.sv
// Checker for lpo_top: bus answer timing and port G ownership.
// Assumes ce_i is held high while the block is being judged.
`timescale 1ns/10ps
`default_nettype none
module lpo_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire lpo_pkg::lpo_wb_req_t wb_req_i,
    input wire logic wb_ack_o,
    input wire logic [4:0] pg_pad_i,
    input wire lpo_pkg::lpo_ovr_t [4:0] pg_ovr_o,
    input wire logic timer0_count_source_o,
    input wire logic timer1_count_source_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    lpo_pkg::lpo_ovr_t [4:0] o; // Short alias for the pin bundles
    logic u4; // Timer 0 pin held by the LCD
    logic u3; // Timer 1 pin held by the LCD
    assign o = pg_ovr_o;
    assign u4 = o[4].input_enable_override_enable;
    assign u3 = o[3].input_enable_override_enable;
    // A request that has not yet been answered
    sequence s_req;
        ce_i && wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
    endsequence
    a_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer missing or too long");
    a_g4_fields: assert property (o[4].pullup_override_enable |->
        o[4].direction_override_value && o[4].analog_pad_link && u4
        && !o[4].input_enable_override_value)
        else $error("pin 4 override fields wrong");
    a_g3_nested: assert property (u3 |-> u4 &&
        !o[3].direction_override_value && o[3].analog_pad_link)
        else $error("pin 3 taken without pin 4");
    a_g2_base: assert property (o[0].analog_pad_link |->
        o[2].direction_override_enable && !o[2].direction_override_value)
        else $error("pin 2 not taken with pin 0");
    a_g10_under: assert property (u4 |->
        o[1].direction_override_enable && o[0].input_enable_override_enable)
        else $error("pins 1 and 0 not taken under pin 4");
    a_g10_link: assert property (o[1].analog_pad_link ==
        o[0].analog_pad_link) else $error("pins 1 and 0 links differ");
    // Bit 4 of each bundle is its value override enable
    a_no_drive: assert property ({o[4][4], o[3][4], o[2][4],
        o[1][4], o[0][4]} == 5'h00) else $error("value override set");
    a_t0_gated: assert property (u4 ##1 u4 |-> !timer0_count_source_o)
        else $error("timer 0 source not gated");
    // Two free cycles so either gating point has settled
    a_t1_follow: assert property (!rst_i && !u3 ##1 !u3 |->
        timer1_count_source_o == $past(pg_pad_i[3]))
        else $error("timer 1 source not following pad");
endmodule
bind lpo_top lpo_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .pg_pad_i(pg_pad_i),
    .pg_ovr_o(pg_ovr_o), .timer0_count_source_o(timer0_count_source_o),
    .timer1_count_source_o(timer1_count_source_o));
`default_nettype wire

// ===== tb/testbench.sv
// Bench for lpo_top: register tests and the LCD ownership table.
// Assumes lpo_pads stands in for the port A and B pads.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [31:0] zero = 32'h0000_0000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1; // Clock enable, dropped once to prove the freeze
    lpo_pkg::lpo_wb_req_t req = '0;
    lpo_pkg::lpo_ovr_t [4:0] ovr;
    logic [31:0] dat, rd;
    logic [7:0] ao, ae, bo, be, ap, bp;
    logic [7:0] ext = 8'h3c; // Outside level on undriven pins
    logic [4:0] gp = 5'h1f; // Port G pads all high
    logic [4:0] own, seen;
    logic ack, t0, t1, on;
    logic [3:0] m;
    int mismatches = 0;
    int tests_run = 0;
    logic [7:0] adr [4] = '{8'h00, 8'h04, 8'h0c, 8'h10};
    logic [7:0] pat [4] = '{8'ha5, 8'hf0, 8'h5a, 8'h0f};
    logic [7:0] lcd [8] = '{8'h71, 8'h70, 8'h01, 8'h11, 8'h51, 8'h61,
        8'h71, 8'h00};
    always #12.5 clk_i = ~clk_i;
    lpo_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req),
        .wb_dat_o(dat), .wb_ack_o(ack), .pa_pad_i(ap), .pa_out_o(ao),
        .pa_oe_o(ae), .pb_pad_i(bp), .pb_out_o(bo), .pb_oe_o(be),
        .pg_pad_i(gp), .pg_ovr_o(ovr), .timer0_count_source_o(t0),
        .timer1_count_source_o(t1));
    lpo_pads u_pa (.out_i(ao), .oe_i(ae), .ext_i(ext), .pad_o(ap));
    lpo_pads u_pb (.out_i(bo), .oe_i(be), .ext_i(~ext), .pad_o(bp));
    task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp);
        tests_run++;
        if (seen_v !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, seen_v, exp);
        end
    endtask
    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat;
        req <= '0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Whole run needs under two hundred cycles
    initial begin
        #(25 * 3000);
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (adr[i]) begin
            xfer(1'b0, adr[i], zero);
            chk(rd, zero);
            xfer(1'b1, adr[i], {24'h00_0000, pat[i]});
            xfer(1'b0, adr[i], zero);
            chk(rd, {24'h00_0000, pat[i]});
        end
        chk({ae, ao, be, bo}, 32'hf0a5_0f5a);
        xfer(1'b0, 8'h08, zero);
        chk(rd, 32'h0000_00ac);
        xfer(1'b0, 8'h14, zero);
        chk(rd, 32'h0000_00ca);
        xfer(1'b0, 8'h40, zero);
        chk(rd, zero);
        $display("port register test done");
        // Clock enable low: a held write must wait and outputs stay frozen
        ce_i <= 1'b0;
        fork
            xfer(1'b1, 8'h00, 32'h0000_003c);
            begin
                repeat (4) @(posedge clk_i);
                chk({24'h00_0000, ao}, 32'h0000_00a5);
                ce_i <= 1'b1;
            end
        join
        repeat (2) @(posedge clk_i);
        chk({24'h00_0000, ao}, 32'h0000_003c);
        $display("clock enable test done");
        foreach (lcd[i]) begin
            on = lcd[i][0];
            m = lcd[i][7:4];
            own = {on && m > 4'h5, on && m > 4'h6, on, {2{on && m > 4'h0}}};
            xfer(1'b1, 8'h18, {24'h00_0000, lcd[i]});
            repeat (2) @(posedge clk_i);
            for (int p = 0; p < 5; p++) seen[p] = ovr[p].analog_pad_link;
            chk({27'h0, seen}, {27'h0, own});
            chk({30'h0, t1, t0}, {30'h0, !own[3], !own[4]});
            xfer(1'b0, 8'h1c, zero);
            chk(rd, {27'h0, own});
        end
        // LCD now off: timer sources must follow the pads down
        gp <= 5'h00;
        repeat (3) @(posedge clk_i);
        chk({30'h0, t1, t0}, zero);
        $display("port G ownership test done");
        complete_run();
    end
endmodule
`default_nettype wire
